// ---- core/cspm_power_seq.sv ----
// Card slot controller power state sequencer
// Summary of operation
// - D0 forwards status-change and functional interrupts
// - D0 lets processor accesses reach cards once resume is done
// - D0 slot power follows software setting
// - D0 forwards status-change from unpowered card
// - D1 masks status-change and functional interrupts
// - D1 status-change pin event raises wake
// - D1 never raises functional interrupts
// - D1 keeps slot power and wake enable register values
// - D1 blocks processor accesses to cards
// - D1 freezes slot power at entry
// - D1 resume is quicker than D3
// - D1 response never faster than D0
// - D2 behaves exactly like D1
// - D3 ignores events, power off, context lost
// - Leaving D3 restores power-on defaults
`timescale 1ns/1ps
module cspm_power_seq #(
    parameter int NUM_SLOTS = 2,
    parameter bit D1_SUPPORTED = 1'b1,
    parameter bit D2_SUPPORTED = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Power state command
    input wire cspm_pkg::cspm_cmd_t cmd_in,
    // Software configuration
    input wire logic cfg_we_in,
    input wire logic cfg_wake_en_in,
    input wire logic [NUM_SLOTS-1:0] cfg_slot_power_in,
    // Card side events
    input wire logic [NUM_SLOTS-1:0] card_status_change_pin_in,
    input wire logic [NUM_SLOTS-1:0] card_func_irq_in,
    // Processor access toward the cards
    input wire logic acc_req_in,
    output logic acc_busy_out,
    output cspm_pkg::cspm_resp_t acc_resp_out,
    // Host interrupts and wake
    output logic [NUM_SLOTS-1:0] status_change_irq_out,
    output logic [NUM_SLOTS-1:0] func_irq_out,
    output logic wake_out,
    // Slot power and status
    output logic [NUM_SLOTS-1:0] slot_power_out,
    output logic [1:0] power_state_out,
    output logic ready_out
);
    import cspm_pkg::*;

    function automatic logic state_supported(input logic [1:0] s);
        state_supported = (s == PS_D0) || (s == PS_D3) ||
            ((s == PS_D1) && D1_SUPPORTED) || ((s == PS_D2) && D2_SUPPORTED);
    endfunction

    logic [1:0] ps;
    logic wake_en;
    logic [NUM_SLOTS-1:0] power_ctrl;
    logic [NUM_SLOTS-1:0] pin_q;
    logic [RESUME_W-1:0] resume_cnt;
    cspm_acc_state_t acc_state;
    logic [ACC_W-1:0] acc_cnt;
    logic acc_grant;

    // Decoding
    wire cmd_ok = cmd_in.valid && state_supported(cmd_in.state);
    wire low_state = (ps == PS_D1) || (ps == PS_D2);
    wire in_d3 = (ps == PS_D3);
    wire to_d0 = cmd_ok && (cmd_in.state == PS_D0);
    wire to_d3 = cmd_ok && (cmd_in.state == PS_D3);
    wire leaving_d3 = to_d0 && in_d3;
    wire resuming = (resume_cnt != '0);
    wire d0_ready = (ps == PS_D0) && !resuming;
    wire [NUM_SLOTS-1:0] sc_event = card_status_change_pin_in & ~pin_q;
    wire [1:0] next_ps = cmd_ok ? cmd_in.state : ps;
    wire sw_write = cfg_we_in && d0_ready;
    wire ctx_clear = to_d3 || in_d3;
    wire [NUM_SLOTS-1:0] next_power_ctrl = ctx_clear ? '0 :
        (sw_write ? cfg_slot_power_in : power_ctrl);
    wire next_wake_en = ctx_clear ? WAKE_EN_RESET :
        (sw_write ? cfg_wake_en_in : wake_en);
    wire [NUM_SLOTS-1:0] next_slot_power = in_d3 ? '0 : power_ctrl;
    wire [NUM_SLOTS-1:0] next_sc_irq = (ps == PS_D0) ? sc_event : '0;
    wire [NUM_SLOTS-1:0] next_func_irq =
        (ps == PS_D0) ? card_func_irq_in : '0;
    wire wake_set = low_state && wake_en && (|sc_event);
    wire next_wake = wake_set || (wake_out && !to_d0);
    wire [RESUME_W-1:0] next_resume_cnt =
        leaving_d3 ? RESUME_W'(RESUME_D3_CYC) :
        ((to_d0 && low_state) ? RESUME_W'(RESUME_LOW_CYC) :
        (resuming ? resume_cnt - 1'b1 : resume_cnt));
    wire next_ready = (next_ps == PS_D0) && (next_resume_cnt == '0);
    wire acc_take = (acc_state == ACC_IDLE) && acc_req_in;
    wire [ACC_W-1:0] acc_load = d0_ready ? ACC_W'(ACC_D0_CYC) :
        ACC_W'(ACC_LOW_CYC);
    wire acc_done = (acc_state == ACC_WAIT) && (acc_cnt == ACC_W'(1));

    // Power state and context
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            ps <= PS_RESET;
            power_ctrl <= '0;
            wake_en <= WAKE_EN_RESET;
            resume_cnt <= '0;
        end else begin
            ps <= next_ps;
            power_ctrl <= next_power_ctrl;
            wake_en <= next_wake_en;
            resume_cnt <= next_resume_cnt;
        end
    end

    // Card events and host side outputs
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            pin_q <= '0;
            status_change_irq_out <= '0;
            func_irq_out <= '0;
            wake_out <= 1'b0;
            slot_power_out <= '0;
            power_state_out <= PS_RESET;
            ready_out <= 1'b1;
        end else begin
            pin_q <= card_status_change_pin_in;
            status_change_irq_out <= next_sc_irq;
            func_irq_out <= next_func_irq;
            wake_out <= next_wake;
            slot_power_out <= next_slot_power;
            power_state_out <= next_ps;
            ready_out <= next_ready;
        end
    end

    // Processor access sequencer
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            acc_state <= ACC_IDLE;
            acc_cnt <= '0;
            acc_grant <= 1'b0;
            acc_busy_out <= 1'b0;
            acc_resp_out <= '0;
        end else begin
            acc_resp_out <= '0;
            if (acc_take) begin
                acc_state <= ACC_WAIT;
                acc_cnt <= acc_load;
                acc_grant <= d0_ready;
                acc_busy_out <= 1'b1;
            end else if (acc_done) begin
                acc_state <= ACC_IDLE;
                acc_busy_out <= 1'b0;
                acc_resp_out.ack <= acc_grant;
                acc_resp_out.blocked <= !acc_grant;
            end else if (acc_state == ACC_WAIT) begin
                acc_cnt <= acc_cnt - 1'b1;
            end
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_d0_sc_forward: assert property (
        ((ps == PS_D0) && (|sc_event)) |=>
            (status_change_irq_out == $past(sc_event)))
        else $error("status change not forwarded in D0");
    a_d0_func_forward: assert property (
        (ps == PS_D0) |=> (func_irq_out == $past(card_func_irq_in)))
        else $error("functional interrupt not forwarded in D0");
    a_low_irq_masked: assert property (
        low_state |=> ((status_change_irq_out == '0) &&
            (func_irq_out == '0)))
        else $error("interrupt leaked in low state");
    a_low_wake_event: assert property (
        (low_state && wake_en && (|sc_event)) |=> wake_out)
        else $error("wake not raised on status change");
    a_low_ctx_kept: assert property (
        (low_state && !to_d3) |=>
            ($stable(power_ctrl) && $stable(wake_en)))
        else $error("context changed in low state");
    a_low_power_frozen: assert property (
        (low_state ##1 low_state) |=> $stable(slot_power_out))
        else $error("slot power moved in low state");
    a_low_acc_blocked: assert property (
        (acc_take && !d0_ready) |-> ##4
            (acc_resp_out.blocked && !acc_resp_out.ack))
        else $error("access not blocked after latency");
    a_d0_acc_ack: assert property (
        (acc_take && d0_ready) |-> ##2 acc_resp_out.ack)
        else $error("access not answered in D0");
    a_acc_busy_take: assert property (
        acc_take |=> acc_busy_out)
        else $error("busy not raised on access");
    a_wake_cleared: assert property (
        (to_d0 && !wake_set) |=> !wake_out)
        else $error("wake not cleared by D0 command");
    a_d3_irq_quiet: assert property (
        in_d3 |=> ((status_change_irq_out == '0) &&
            (func_irq_out == '0)))
        else $error("interrupt raised in D3");
    a_d0_power_follow: assert property (
        (ps == PS_D0) |=> (slot_power_out == $past(power_ctrl)))
        else $error("slot power not following setting");
    a_low_not_ready: assert property (
        low_state |-> !ready_out)
        else $error("ready shown in low state");
    a_resume_cfg_refused: assert property (
        ((ps == PS_D0) && resuming && !to_d3) |=>
            ($stable(power_ctrl) && $stable(wake_en)))
        else $error("setting written during resume");
    a_d3_resume_slow: assert property (
        leaving_d3 |-> ##30 !ready_out)
        else $error("D3 resume not slower than low state");
    a_cmd_state_out: assert property (
        cmd_ok |=> (power_state_out == $past(cmd_in.state)))
        else $error("state output not updated on command");

    // Per slot status-change pulse
    for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot_chk
        a_slot_sc_pulse: assert property (
            status_change_irq_out[i] |=> !status_change_irq_out[i])
            else $error("status change pulse too long");
    end
    a_d3_power_off: assert property (
        in_d3 |=> (slot_power_out == '0))
        else $error("slot power on in D3");
    a_d3_exit_defaults: assert property (
        leaving_d3 |=> ((power_ctrl == '0) && (wake_en == WAKE_EN_RESET)
            && !ready_out))
        else $error("defaults not restored from D3");
    a_low_resume_fast: assert property (
        (to_d0 && low_state) |-> ##[1:30] ready_out)
        else $error("low state resume too slow");
    a_state_hold: assert property (
        !cmd_ok |=> (ps == $past(ps)))
        else $error("state changed without command");

    c_wake_raised: cover property (wake_set ##1 wake_out);
    c_d0_access: cover property (acc_take && d0_ready ##2 acc_resp_out.ack);
    c_low_access: cover property (acc_take && low_state ##4
        acc_resp_out.blocked);
    c_d3_exit: cover property (leaving_d3 ##[1:300] ready_out);
endmodule

// ---- core/cspm_pkg.sv ----
// Shared constants and carrier types for the card slot power sequencer
package cspm_pkg;
    // Clock period in ns
    localparam int CLK_PERIOD_NS = 40;
    // Power state codes, D0 to D3
    localparam logic [1:0] PS_D0 = 2'h0;
    localparam logic [1:0] PS_D1 = 2'h1;
    localparam logic [1:0] PS_D2 = 2'h2;
    localparam logic [1:0] PS_D3 = 2'h3;
    localparam logic [1:0] PS_RESET = PS_D0;
    // Restore times after a return to D0
    localparam int RESUME_LOW_NS = 1000;
    localparam int RESUME_D3_NS = 10000;
    localparam int RESUME_LOW_CYC = (RESUME_LOW_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int RESUME_D3_CYC = (RESUME_D3_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int RESUME_W = 9;
    // Bus command response latency in cycles
    localparam int ACC_D0_CYC = 1;
    localparam int ACC_LOW_CYC = 3;
    localparam int ACC_W = 2;
    // Reset values
    localparam logic WAKE_EN_RESET = 1'b0;
    // Access sequencer states
    typedef enum logic {ACC_IDLE, ACC_WAIT} cspm_acc_state_t;
    // Power state command from the host
    typedef struct packed {
        logic valid;
        logic [1:0] state;
    } cspm_cmd_t;
    // Answer to a processor access toward the cards
    typedef struct packed {
        logic ack;
        logic blocked;
    } cspm_resp_t;
endpackage

// ---- sim/cspm_card_model.sv ----
// Card slot model: inserted cards as seen by the slot controller
`timescale 1ns/1ps
module cspm_card_model #(
    parameter int NUM_SLOTS = 2
) (
    // Clock and stimulus
    input wire logic ref_clk_in,
    input wire logic [NUM_SLOTS-1:0] insert_in,
    input wire logic [NUM_SLOTS-1:0] attn_in,
    input wire logic [1:0] host_state_in,
    // Card pins
    output logic [NUM_SLOTS-1:0] card_status_change_pin_out,
    output logic [NUM_SLOTS-1:0] card_func_irq_out,
    output logic [1:0] card_state_out
);
    import cspm_pkg::*;
    logic [NUM_SLOTS-1:0] held = '0;
    initial card_status_change_pin_out = '0;
    initial card_state_out = PS_D0;
    // Status pin held two cycles, then pulled low
    always @(posedge ref_clk_in) begin
        held <= insert_in;
        card_status_change_pin_out <= insert_in | held;
        card_state_out <= (host_state_in == PS_D0) ? PS_D0 : PS_D3;
    end
    assign card_func_irq_out = attn_in;
endmodule

// ---- sim/test_cspm_power_seq.sv ----
// Self-checking testbench for the card slot power sequencer
`timescale 1ns/1ps
module test_cspm_power_seq;
    import cspm_pkg::*;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    cspm_cmd_t cmd_in = '0;
    logic cfg_we_in = 1'b0;
    logic cfg_wake_en_in = 1'b0;
    logic [1:0] cfg_slot_power_in = 2'h0;
    logic [1:0] insert = 2'h0;
    logic [1:0] attn = 2'h0;
    logic acc_req_in = 1'b0;
    logic [1:0] pin, func, sc_irq, fi_irq, slot_pwr, pstate;
    logic busy, wake, ready;
    cspm_resp_t resp;
    int n_fail = 0;
    int checks = 0;
    int n, n_low;
    always #(CLK_PERIOD_NS / 2) ref_clk_in = ~ref_clk_in;
    cspm_power_seq DUT (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .cmd_in(cmd_in), .cfg_we_in(cfg_we_in),
        .cfg_wake_en_in(cfg_wake_en_in), .cfg_slot_power_in(cfg_slot_power_in),
        .card_status_change_pin_in(pin), .card_func_irq_in(func),
        .acc_req_in(acc_req_in), .acc_busy_out(busy), .acc_resp_out(resp),
        .status_change_irq_out(sc_irq), .func_irq_out(fi_irq),
        .wake_out(wake), .slot_power_out(slot_pwr),
        .power_state_out(pstate), .ready_out(ready));
    cspm_card_model cards (.ref_clk_in(ref_clk_in), .insert_in(insert),
        .attn_in(attn), .host_state_in(pstate),
        .card_status_change_pin_out(pin), .card_func_irq_out(func),
        .card_state_out());
    function automatic logic sel(input int k);
        case (k)
            0: return sc_irq[0];
            1: return wake;
            2: return ready;
            3: return resp.ack;
            default: return resp.blocked;
        endcase
    endfunction
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask
    task automatic wait_for(input int k, input int lim, output int c);
        c = 0;
        do begin
            @(posedge ref_clk_in);
            #1;
            c++;
        end while (sel(k) !== 1'b1 && c < lim);
    endtask
    task automatic go_state(input logic [1:0] s);
        @(posedge ref_clk_in) cmd_in <= '{valid: 1'b1, state: s};
        @(posedge ref_clk_in) cmd_in <= '0;
        @(posedge ref_clk_in);
        #1;
    endtask
    task automatic cfg(input logic w, input logic [1:0] p);
        @(posedge ref_clk_in) cfg_we_in <= 1'b1;
        cfg_wake_en_in <= w;
        cfg_slot_power_in <= p;
        @(posedge ref_clk_in) cfg_we_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic card_event();
        @(posedge ref_clk_in) insert <= 2'h1;
        @(posedge ref_clk_in) insert <= 2'h0;
    endtask
    task automatic access();
        @(posedge ref_clk_in) acc_req_in <= 1'b1;
        @(posedge ref_clk_in) acc_req_in <= 1'b0;
    endtask
    task automatic t_full_power();
        cfg(1'b1, 2'h2);
        chk("slot power", 8'h02, slot_pwr);
        @(posedge ref_clk_in) attn <= 2'h3;
        repeat (3) @(posedge ref_clk_in);
        #1;
        chk("func irq d0", 8'h03, fi_irq);
        attn <= 2'h0;
        card_event();
        wait_for(0, 4, n);
        chk("irq unpowered slot", 8'h01, 8'(n));
        @(posedge ref_clk_in);
        #1;
        chk("irq pulse end", 8'h00, sc_irq);
        chk("wake d0", 8'h00, wake);
        access();
        #1;
        chk("access busy", 8'h01, busy);
        wait_for(3, 8, n);
        chk("access ack delay", 8'(ACC_D0_CYC), 8'(n));
        chk("access busy end", 8'h00, busy);
    endtask
    task automatic t_low(input logic [1:0] s);
        go_state(s);
        chk("state code", 8'(s), pstate);
        chk("ready low", 8'h00, ready);
        @(posedge ref_clk_in) attn <= 2'h3;
        cfg(1'b0, 2'h1);
        chk("power frozen", 8'h02, slot_pwr);
        chk("func irq masked", 8'h00, fi_irq);
        attn <= 2'h0;
        card_event();
        wait_for(1, 4, n);
        chk("wake delay", 8'h01, 8'(n));
        chk("status irq masked", 8'h00, sc_irq);
        access();
        wait_for(4, 8, n);
        chk("blocked delay", 8'(ACC_LOW_CYC), 8'(n));
        go_state(PS_D0);
        chk("wake cleared", 8'h00, wake);
        wait_for(2, 400, n_low);
        chk("resume done", 8'h01, ready);
    endtask
    task automatic t_off();
        go_state(PS_D3);
        chk("power off d3", 8'h00, slot_pwr);
        card_event();
        repeat (3) @(posedge ref_clk_in);
        #1;
        chk("no wake d3", 8'h00, wake);
        go_state(PS_D0);
        wait_for(2, 400, n);
        chk("slower d3 resume", 8'h01, 8'(n > n_low));
        chk("d3 exit power", 8'h00, slot_pwr);
        cfg(1'b1, 2'h3);
        @(posedge ref_clk_in) reset_n_in <= 1'b0;
        @(posedge ref_clk_in) reset_n_in <= 1'b1;
        #1;
        chk("defaults power", 8'h00, slot_pwr);
        chk("defaults state", 8'(PS_RESET), pstate);
    endtask
    task automatic complete_run();
        if (n_fail == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        @(posedge ref_clk_in);
        #1;
        chk("reset state", 8'(PS_D0), pstate);
        chk("reset ready", 8'h01, ready);
        t_full_power();
        t_low(PS_D1);
        t_low(PS_D2);
        t_off();
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge ref_clk_in);
        n_fail++;
        complete_run();
    end
endmodule
